// file: cpm_cell.sv
// Logic cell register with clocking, control, output and lock options
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps

// Summary of operation
// - Four dedicated pins: clock, clear, two enables
// - Clock modes: global, gated global, array
// - Array clock is product term of pins/cells
// - Basic variant: one global clock, pin A
// - Enhanced: two nets, true/inverted, either pin
// - Product-term preset and clear, active high
// - Optional global clear, pin low clears
// - Power-up leaves cell register at zero
// - Enhanced: fast pin path to D input
// - Five product terms plus shared, parallel expanders
// - Speed/power bit; low power adds delay
// - Enhanced: optional open-drain pin drive
// - Security bit blocks configuration readback
// - Configuration set back to its reset values by reprogram cycle or by reset
module cpm_cell (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire cpm_pkg::cpm_apb_req_t apbReq,
    output      cpm_pkg::cpm_apb_rsp_t apbRsp,
    input  wire logic [3:0]            dedicatedPin,
    input  wire logic [3:0]            ioPin,
    input  wire logic [3:0]            buriedCell,
    input  wire logic [4:0]            productTerm,
    input  wire logic                  shareExpander,
    input  wire logic                  parallelExpander,
    input  wire logic                  clockEnable,
    input  wire logic                  presetTerm,
    input  wire logic                  clearTerm,
    output      logic [3:0]            pinLevel,
    output      logic                  cellQ,
    output      logic                  pinOut,
    output      logic                  pinOe
);
    import cpm_pkg::*;

    cpm_state_t s;
    cpm_state_t next_s;

    // ************************************************************
    // Combinational next state
    // ************************************************************
    always_comb begin
        logic          enh;
        logic          net0;
        logic          net1;
        logic          globalClk;
        logic          arrayClk;
        logic          clkSrc;
        logic          clkEdge;
        logic          edgeEn;
        logic [7:0]    lits;
        logic          dIn;
        logic          fire;
        logic          dUse;
        logic          clrAll;
        logic          setup;
        logic          access;
        logic [31:0]   rd;
        logic          err;
        cpm_clk_mode_t mode;

        next_s    = s;
        enh       = s.cfg.ctrl[CPM_CTRL_ENH];
        mode      = cpm_clk_mode_t'(s.cfg.ctrl[CPM_CTRL_MODE_LO +: 2]);
        rd        = 32'h0000_0000;
        err       = 1'b0;
        net0      = 1'b0;
        net1      = 1'b0;
        globalClk = 1'b0;
        arrayClk  = 1'b0;
        clkSrc    = 1'b0;
        clkEdge   = 1'b0;
        edgeEn    = 1'b0;
        lits      = 8'h00;
        dIn       = 1'b0;
        fire      = 1'b0;
        dUse      = 1'b0;
        clrAll    = 1'b0;
        setup     = 1'b0;
        access    = 1'b0;

        // Pin synchronisers, level taken once stages two and three agree
        next_s.sync.ded1 = dedicatedPin;
        next_s.sync.ded2 = s.sync.ded1;
        next_s.sync.ded3 = s.sync.ded2;
        next_s.sync.io1  = ioPin;
        next_s.sync.io2  = s.sync.io1;
        next_s.sync.io3  = s.sync.io2;
        for (int i = 0; i < 4; i++) begin
            if (s.sync.ded2[i] == s.sync.ded3[i]) begin
                next_s.sync.ded[i] = s.sync.ded3[i];
            end
            if (s.sync.io2[i] == s.sync.io3[i]) begin
                next_s.sync.io[i] = s.sync.io3[i];
            end
        end

        // ************************************************************
        // Clock selection
        // ************************************************************
        if (enh) begin
            net0 = (s.cfg.net[CPM_NET0_SRC] ? s.sync.ded[CPM_PIN_CLKB]
                                            : s.sync.ded[CPM_PIN_CLKA])
                   ^ s.cfg.net[CPM_NET0_INV];
            net1 = (s.cfg.net[CPM_NET1_SRC] ? s.sync.ded[CPM_PIN_CLKB]
                                            : s.sync.ded[CPM_PIN_CLKA])
                   ^ s.cfg.net[CPM_NET1_INV];
            globalClk = s.cfg.ctrl[CPM_CTRL_NETSEL] ? net1 : net0;
        end else begin
            net0      = s.sync.ded[CPM_PIN_CLKA];
            net1      = net0;
            globalClk = net0;
        end

        // Array clock: AND of selected true and complement literals
        lits     = {s.sync.io, buriedCell};
        arrayClk = (&(lits | ~s.cfg.term[7:0]))
                 & (&(~lits | ~s.cfg.term[15:8]));

        unique case (mode)
            CPM_CLK_GLOBAL: begin
                clkSrc = globalClk;
            end
            CPM_CLK_GATED: begin
                clkSrc = globalClk;
            end
            CPM_CLK_ARRAY: begin
                clkSrc = arrayClk;
            end
            default: begin
                clkSrc = globalClk;
            end
        endcase

        next_s.prevClk = clkSrc;
        clkEdge        = clkSrc & ~s.prevClk;
        edgeEn         = clkEdge & ((mode != CPM_CLK_GATED) | clockEnable);

        // ************************************************************
        // Data input
        // ************************************************************
        if (enh && s.cfg.ctrl[CPM_CTRL_FAST]) begin
            dIn = s.sync.io[0];
        end else begin
            dIn = (|productTerm) | shareExpander | parallelExpander;
        end

        // Low power cells see capture one adder later
        next_s.lpEdge = CPM_LPA_CYCLES'({s.lpEdge, edgeEn});
        next_s.lpData = CPM_LPA_CYCLES'({s.lpData, dIn});
        if (s.cfg.ctrl[CPM_CTRL_SPEED]) begin
            fire = edgeEn;
            dUse = dIn;
        end else begin
            fire = s.lpEdge[CPM_LPA_CYCLES-1];
            dUse = s.lpData[CPM_LPA_CYCLES-1];
        end

        // ************************************************************
        // Register with overriding preset and clear
        // ************************************************************
        clrAll = clearTerm
               | (s.cfg.ctrl[CPM_CTRL_GCLR] & ~s.sync.ded[CPM_PIN_CLRN]);
        if (clrAll) begin
            next_s.q = 1'b0;
        end else if (presetTerm) begin
            next_s.q = 1'b1;
        end else if (fire) begin
            next_s.q = dUse;
        end

        // Pin drive from the register
        if (enh && s.cfg.ctrl[CPM_CTRL_ODRAIN]) begin
            next_s.pinOut = 1'b0;
            next_s.pinOe  = ~next_s.q;
        end else begin
            next_s.pinOut = next_s.q;
            next_s.pinOe  = s.cfg.ctrl[CPM_CTRL_OESEL] ? s.sync.ded[CPM_PIN_CLKB]
                                                       : s.sync.ded[CPM_PIN_OEA];
        end

        // ************************************************************
        // APB slave
        // ************************************************************
        setup  = apbReq.psel & ~apbReq.penable;
        access = apbReq.psel & apbReq.penable;

        unique case (apbReq.paddr)
            CPM_CTRL_ADDR: begin
                if (s.cfg.ctrl[CPM_CTRL_SECURE]) begin
                    err = ~apbReq.pwrite;
                end else begin
                    rd = {22'h000000, s.cfg.ctrl};
                end
            end
            CPM_NET_ADDR: begin
                if (s.cfg.ctrl[CPM_CTRL_SECURE]) begin
                    err = ~apbReq.pwrite;
                end else begin
                    rd = {28'h0000000, s.cfg.net};
                end
            end
            CPM_TERM_ADDR: begin
                if (s.cfg.ctrl[CPM_CTRL_SECURE]) begin
                    err = ~apbReq.pwrite;
                end else begin
                    rd = {16'h0000, s.cfg.term};
                end
            end
            CPM_STATUS_ADDR: begin
                rd[CPM_STAT_Q]      = s.q;
                rd[CPM_STAT_SECURE] = s.cfg.ctrl[CPM_CTRL_SECURE];
                rd[CPM_STAT_ENH]    = enh;
            end
            CPM_REPROG_ADDR: begin
                rd = 32'h0000_0000;
            end
            default: begin
                err = 1'b1;
            end
        endcase

        if (setup) begin
            next_s.rdata = rd;
            next_s.rerr  = err;
        end

        if (access && apbReq.pwrite && !s.rerr) begin
            unique case (apbReq.paddr)
                CPM_CTRL_ADDR: begin
                    next_s.cfg.ctrl = apbReq.pwdata[9:0];
                    // Lock stays set until reprogrammed or reset
                    next_s.cfg.ctrl[CPM_CTRL_SECURE] = s.cfg.ctrl[CPM_CTRL_SECURE]
                                                     | apbReq.pwdata[CPM_CTRL_SECURE];
                end
                CPM_NET_ADDR: begin
                    next_s.cfg.net = apbReq.pwdata[3:0];
                end
                CPM_TERM_ADDR: begin
                    next_s.cfg.term = apbReq.pwdata[15:0];
                end
                CPM_REPROG_ADDR: begin
                    if (apbReq.pwdata[CPM_REPROG_GO]) begin
                        next_s.cfg.ctrl = CPM_CTRL_RST;
                        next_s.cfg.net  = CPM_NET_RST;
                        next_s.cfg.term = CPM_TERM_RST;
                    end
                end
                default: begin
                    next_s.cfg = s.cfg;
                end
            endcase
        end
    end

    // ************************************************************
    // State register, power-up state
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s          <= '0;
            s.cfg.ctrl <= CPM_CTRL_RST;
            s.cfg.net  <= CPM_NET_RST;
            s.cfg.term <= CPM_TERM_RST;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign apbRsp.prdata  = s.rdata;
    assign apbRsp.pready  = 1'b1;
    assign apbRsp.pslverr = s.rerr & apbReq.psel & apbReq.penable;
    assign pinLevel       = s.sync.ded;
    assign cellQ          = s.q;
    assign pinOut         = s.pinOut;
    assign pinOe          = s.pinOe;

endmodule

// file: cpm_pkg.sv
// Constants and carrier types for the logic cell register block
package cpm_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CPM_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] CPM_NET_ADDR    = 8'h04;
    localparam logic [7:0] CPM_TERM_ADDR   = 8'h08;
    localparam logic [7:0] CPM_STATUS_ADDR = 8'h0c;
    localparam logic [7:0] CPM_REPROG_ADDR = 8'h10;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CPM_CTRL_MODE_LO = 0;
    localparam int CPM_CTRL_NETSEL  = 2;
    localparam int CPM_CTRL_ENH     = 3;
    localparam int CPM_CTRL_FAST    = 4;
    localparam int CPM_CTRL_GCLR    = 5;
    localparam int CPM_CTRL_SPEED   = 6;
    localparam int CPM_CTRL_ODRAIN  = 7;
    localparam int CPM_CTRL_SECURE  = 8;
    localparam int CPM_CTRL_OESEL   = 9;
    localparam int CPM_NET0_SRC     = 0;
    localparam int CPM_NET0_INV     = 1;
    localparam int CPM_NET1_SRC     = 2;
    localparam int CPM_NET1_INV     = 3;
    localparam int CPM_STAT_Q       = 0;
    localparam int CPM_STAT_SECURE  = 1;
    localparam int CPM_STAT_ENH     = 2;
    localparam int CPM_REPROG_GO    = 0;

    // Dedicated pin positions
    localparam int CPM_PIN_CLKA = 0;
    localparam int CPM_PIN_CLRN = 1;
    localparam int CPM_PIN_OEA  = 2;
    localparam int CPM_PIN_CLKB = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [9:0]  CPM_CTRL_RST = 10'h060;
    localparam logic [3:0]  CPM_NET_RST  = 4'h0;
    localparam logic [15:0] CPM_TERM_RST = 16'h0000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CPM_CLK_PERIOD_NS = 100;
    localparam int CPM_LPA_NS        = 11;
    localparam int CPM_LPA_CYC_RAW   = (CPM_LPA_NS + CPM_CLK_PERIOD_NS - 1) / CPM_CLK_PERIOD_NS;
    localparam int CPM_LPA_CYCLES    = (CPM_LPA_CYC_RAW < 1) ? 1 : CPM_LPA_CYC_RAW;

    typedef enum logic [1:0] {
        CPM_CLK_GLOBAL = 2'b00,
        CPM_CLK_GATED  = 2'b01,
        CPM_CLK_ARRAY  = 2'b10
    } cpm_clk_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cpm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cpm_apb_rsp_t;

    typedef struct packed {
        logic [9:0]  ctrl;
        logic [3:0]  net;
        logic [15:0] term;
    } cpm_cfg_t;

    typedef struct packed {
        logic [3:0] ded1;
        logic [3:0] ded2;
        logic [3:0] ded3;
        logic [3:0] ded;
        logic [3:0] io1;
        logic [3:0] io2;
        logic [3:0] io3;
        logic [3:0] io;
    } cpm_sync_t;

    typedef struct packed {
        cpm_sync_t                  sync;
        cpm_cfg_t                   cfg;
        logic                       prevClk;
        logic [CPM_LPA_CYCLES-1:0]  lpEdge;
        logic [CPM_LPA_CYCLES-1:0]  lpData;
        logic                       q;
        logic                       pinOut;
        logic                       pinOe;
        logic [31:0]                rdata;
        logic                       rerr;
    } cpm_state_t;

endpackage

// file: cpm_cell_assertions.sv
// Assertion checker for the logic cell register
`timescale 1ns/100ps
module cpm_cell_chk (
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire cpm_pkg::cpm_apb_req_t apbReq,
    input wire cpm_pkg::cpm_apb_rsp_t apbRsp,
    input wire logic [3:0]            dedicatedPin,
    input wire logic                  presetTerm,
    input wire logic                  clearTerm,
    input wire logic [3:0]            pinLevel,
    input wire logic                  cellQ
);
    import cpm_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_sync;
        $stable(dedicatedPin)[*8] |-> pinLevel == dedicatedPin;
    endproperty
    a_sync: assert property (p_sync) else $error("pin level lost");
    property p_clr;
        clearTerm |=> !cellQ;
    endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_pre;
        presetTerm && !clearTerm && pinLevel[1] |=> cellQ;
    endproperty
    a_pre: assert property (p_pre) else $error("preset ignored");
    property p_hold;
        clearTerm [*2] |-> !cellQ;
    endproperty
    a_hold: assert property (p_hold) else $error("clear not held");
    property p_gclr;
        !pinLevel[1] && !presetTerm |-> ##[1:2] !cellQ;
    endproperty
    a_gclr: assert property (p_gclr) else $error("pin clear ignored");
    property p_rst;
        $rose(rst_n) |-> !cellQ;
    endproperty
    a_rst: assert property (p_rst) else $error("cell not zero");
    property p_err;
        apbRsp.pslverr |-> apbReq.psel && apbReq.penable && apbRsp.prdata == 32'h0000_0000;
    endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_rdat;
        !(apbReq.psel && !apbReq.penable) |=> $stable(apbRsp.prdata);
    endproperty
    a_rdat: assert property (p_rdat) else $error("read data moved");
    c_clr: cover property (clearTerm && presetTerm);
    c_err: cover property (apbRsp.pslverr);
    c_gclr: cover property ($fell(pinLevel[1]));
endmodule
bind cpm_cell cpm_cell_chk u_cpm_cell_chk (.sys_clk, .rst_n, .apbReq, .apbRsp,
    .dedicatedPin, .presetTerm, .clearTerm, .pinLevel, .cellQ);

// file: cpm_board.sv
// Board model: clock pin pulses and pulled-up open-drain pad
`timescale 1ns/100ps
module cpm_board (
    input  wire logic sys_clk,
    input  wire logic fire,
    input  wire logic slow,
    input  wire logic pinOut,
    input  wire logic pinOe,
    output      logic clkPin,
    output      logic padLevel
);
    logic [4:0] cnt = 5'h00;
    always_ff @(posedge sys_clk) begin
        if (fire) begin
            cnt <= slow ? 5'h18 : 5'h0c;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
        end
    end
    // Low seven cycles, then high five (slow: low 13, high 11), pin idles low
    assign clkPin = (cnt != 5'h00) && (cnt < (slow ? 5'h0c : 5'h06));
    // Pull-up wins when no device drives
    assign padLevel = pinOe ? pinOut : 1'b1;
endmodule

// file: test_cpm_cell.sv
// Testbench for the logic cell register
`timescale 1ns/100ps
module test_cpm_cell;
    import cpm_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
        logic        r;
    } cpm_row_t;
    logic         sys_clk, rst_n, clrN, fire, slow, shE, paE, ce, pre, clr;
    logic         oeA, clkB;
    int           lat, latHs;
    logic         clkPin, padLevel, cellQ, pinOut, pinOe, rerr;
    logic [3:0]   ioP, bur, pinLevel;
    logic [4:0]   pt;
    logic [31:0]  rd;
    cpm_apb_req_t req;
    cpm_apb_rsp_t rsp;
    int           err_count = 0;
    int           checked = 0;
    cpm_row_t     rows [5] = '{'{8'h04, 32'ha, 32'ha, 1'b0}, '{8'h04, 32'h0, 32'h0, 1'b0},
        '{8'h08, 32'ha55a, 32'ha55a, 1'b0}, '{8'h0c, 32'h7, 32'h0, 1'b0},
        '{8'h20, 32'h5, 32'h0, 1'b1}};
    cpm_cell u_cpm_cell (.sys_clk, .rst_n, .apbReq(req), .apbRsp(rsp),
        .dedicatedPin({clkB, oeA, clrN, clkPin}), .ioPin(ioP), .buriedCell(bur),
        .productTerm(pt), .shareExpander(shE), .parallelExpander(paE),
        .clockEnable(ce), .presetTerm(pre), .clearTerm(clr), .pinLevel, .cellQ,
        .pinOut, .pinOe);
    cpm_board u_cpm_board (.sys_clk, .fire, .slow, .pinOut, .pinOe, .clkPin, .padLevel);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic summarize;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic chkq(input logic e);
        chk({31'h0, cellQ}, {31'h0, e});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        @(posedge sys_clk);
        while (rsp.pready !== 1'b1) begin
            if (n++ > 20) begin
                err_count++;
                summarize();
            end
            @(posedge sys_clk);
        end
        rd = rsp.prdata;
        rerr = rsp.pslverr;
        req <= '0;
        @(posedge sys_clk);
    endtask
    task automatic wq(input logic e);
        int n;
        n = 0;
        while (cellQ !== e) begin
            if (n++ > 80) begin
                err_count++;
                summarize();
            end
            @(posedge sys_clk);
        end
        lat = n;
    endtask
    task automatic pulse(input logic s);
        slow <= s;
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic step(input logic p, input logic c);
        pre <= p;
        clr <= c;
        @(posedge sys_clk);
        pre <= 1'b0;
        clr <= 1'b0;
        @(posedge sys_clk);
    endtask
    initial begin
        {rst_n, fire, slow, shE, paE, ce, pre, clr, ioP, bur, pt} = '0;
        clrN = 1'b1;
        {oeA, clkB} = 2'b00;
        req = '0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
            chk({31'h0, rerr}, {31'h0, rows[i].r});
        end
        $display("test table done");
        apb(1'b0, CPM_CTRL_ADDR, 32'h0);
        chk(rd, 32'h60);
        chk({28'h0, pinLevel}, 32'h2);
        chkq(1'b0);
        pt <= 5'h01;
        pulse(1'b0);
        wq(1'b1);
        latHs = lat;
        chkq(1'b1);
        apb(1'b1, CPM_CTRL_ADDR, 32'h61);
        pt <= 5'h00;
        pulse(1'b0);
        repeat (30) @(posedge sys_clk);
        chkq(1'b1);
        ce <= 1'b1;
        pulse(1'b0);
        wq(1'b0);
        chkq(1'b0);
        apb(1'b1, CPM_CTRL_ADDR, 32'h20);
        shE <= 1'b1;
        pulse(1'b1);
        wq(1'b1);
        chkq(1'b1);
        chk(lat, latHs + 6 + CPM_LPA_CYCLES);
        step(1'b0, 1'b1);
        chkq(1'b0);
        {shE, paE} <= 2'b01;
        pulse(1'b0);
        wq(1'b1);
        chkq(1'b1);
        apb(1'b1, CPM_CTRL_ADDR, 32'h62);
        apb(1'b1, CPM_TERM_ADDR, 32'h1);
        paE <= 1'b0;
        bur <= 4'h1;
        wq(1'b0);
        chkq(1'b0);
        step(1'b1, 1'b0);
        chkq(1'b1);
        step(1'b1, 1'b1);
        chkq(1'b0);
        apb(1'b1, CPM_TERM_ADDR, 32'h100);
        {pt, bur} <= 9'h010;
        wq(1'b1);
        chkq(1'b1);
        pt <= 5'h00;
        step(1'b1, 1'b0);
        clrN <= 1'b0;
        wq(1'b0);
        chkq(1'b0);
        chk({28'h0, pinLevel}, 32'h0);
        clrN <= 1'b1;
        apb(1'b1, CPM_CTRL_ADDR, 32'h68);
        apb(1'b1, CPM_NET_ADDR, 32'h2);
        pt <= 5'h01;
        pulse(1'b1);
        repeat (20) @(posedge sys_clk);
        chkq(1'b0);
        wq(1'b1);
        chkq(1'b1);
        apb(1'b1, CPM_CTRL_ADDR, 32'he8);
        chk({31'h0, padLevel}, 32'h1);
        step(1'b0, 1'b1);
        @(posedge sys_clk);
        chk({29'h0, padLevel, pinOut, pinOe}, 32'h1);
        apb(1'b1, CPM_NET_ADDR, 32'h0);
        apb(1'b1, CPM_CTRL_ADDR, 32'h78);
        {pt, ioP} <= 9'h001;
        repeat (6) @(posedge sys_clk);
        pulse(1'b0);
        wq(1'b1);
        chkq(1'b1);
        oeA <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk({30'h0, pinOe, padLevel}, 32'h3);
        ioP <= 4'h0;
        apb(1'b1, CPM_CTRL_ADDR, 32'h7c);
        apb(1'b1, CPM_NET_ADDR, 32'h4);
        clkB <= 1'b1;
        wq(1'b0);
        chkq(1'b0);
        apb(1'b1, CPM_CTRL_ADDR, 32'h160);
        apb(1'b0, CPM_CTRL_ADDR, 32'h0);
        chk({rd[30:0], rerr}, 32'h1);
        apb(1'b0, CPM_STATUS_ADDR, 32'h0);
        chk(rd, 32'h2);
        clrN <= 1'b0;
        repeat (8) @(posedge sys_clk);
        clrN <= 1'b1;
        repeat (8) @(posedge sys_clk);
        apb(1'b0, CPM_CTRL_ADDR, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, CPM_REPROG_ADDR, 32'h1);
        apb(1'b0, CPM_CTRL_ADDR, 32'h0);
        chk(rd, 32'h60);
        $display("test modes done");
        step(1'b1, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chkq(1'b0);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        $display("test reset done");
        summarize();
    end
endmodule
